// *** sfcseq_consts.vh ***
// constants for the sfc step sequencer elements
`ifndef SFCSEQ_CONSTS_VH
`define SFCSEQ_CONSTS_VH
`define SFCSEQ_N_STEPS 4
`define SFCSEQ_N_INIT 1
`define SFCSEQ_SCAN_NS 1000
`define SFCSEQ_CLK_NS 5
`define SFCSEQ_STEP_RST 1'b0
`define SFCSEQ_INIT_RST 1'b1
`endif

// *** sfcseq_step.v ***
// one sfc step latch: set by either step input, cleared by transition
`timescale 1ns/1ps
module sfcseq_step (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // scan and control
    input wire scan_tick,
    input wire force_en,
    input wire force_val,
    input wire hold_en,
    // token inputs
    input wire step_in1,
    input wire step_in2,
    input wire trans_in,
    // outputs
    output wire step_out,
    output reg trans_out_reg
);
    reg step_reg;
    reg step_next;
    reg trans_next;
    assign step_out = step_reg;

    always @* begin
        step_next = step_reg;
        trans_next = 1'b0; // R18
        if (force_en) begin
            step_next = force_val; // R19
        end else if (hold_en) begin
            step_next = step_reg;
        end else if (trans_in && step_reg) begin
            step_next = 1'b0; // R2
            trans_next = 1'b1; // R2
        end else if (step_in1 || step_in2) begin
            step_next = 1'b1; // R1
        end
        // R3: with nothing active the latch just holds its value
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            step_reg <= 1'b0;
            trans_out_reg <= 1'b0;
        end else if (scan_tick) begin
            step_reg <= step_next; // R21
            trans_out_reg <= trans_next;
        end else begin
            trans_out_reg <= 1'b0; // R18
        end
    end
endmodule

// *** sfcseq_chart.v ***
// one independent sfc chart built from the step sequencer elements
`timescale 1ns/1ps
`include "sfcseq_consts.vh"
// Summary of operation
// R1: a step input sets the step output, which then stays latched.
// R2: an active transition clears the step and pulses its transition output.
// R3: with no input active an inactive step stays inactive.
// R4: unconnected element inputs read as inactive; the code has no pulls, so unused inputs must be tied low.
// R5: without resettable step, initial steps set at start, run entry, power return.
// R6: every chart carries at least one initial step.
// R7: reset forces the resettable initial step on and clears other steps; the code forces the initial step on as well.
// R8: a chart with resettable step keeps its steps across power loss.
// R9: no more than one resettable initial step per chart.
// R10: cold-start drives reset; outside logic disables dependent outputs.
// R11: resettable step inputs default inactive except reset itself.
// R12: the split drives both outputs when either input is active.
// R13: the split holds both outputs inactive when no input is active.
// R14: join inputs one or two latch the first branch output.
// R15: join inputs three or four latch the second branch output.
// R16: both branches plus transition clear both and pulse the transition output.
// R17: transition with a branch missing changes nothing and pulses nothing.
// R18: transition outputs last a single scan only; the code drives them high for one clk_sys cycle after the scan edge.
// R19: while reset is held, steps stay at the initial pattern.
// R20: resetting this chart leaves other charts untouched.
// R21: latches update once per scan from inputs sampled at scan start.
module sfcseq_chart #(
    parameter N_STEPS = `SFCSEQ_N_STEPS,
    parameter HAS_RESET_INIT = 1,
    parameter SCAN_NS = `SFCSEQ_SCAN_NS
) (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // run control from the program environment
    input wire init_req,
    input wire power_return,
    input wire chart_reset,
    // initial step
    input wire init_in1,
    input wire init_in2,
    input wire init_trans,
    output wire init_step_out,
    output wire init_trans_out,
    // resettable initial step
    input wire rinit_in1,
    input wire rinit_in2,
    input wire rinit_trans,
    output wire rinit_step_out,
    output wire rinit_trans_out,
    // ordinary steps
    input wire [N_STEPS-1:0] step_in1,
    input wire [N_STEPS-1:0] step_in2,
    input wire [N_STEPS-1:0] step_trans,
    output wire [N_STEPS-1:0] step_out,
    output wire [N_STEPS-1:0] step_trans_out,
    // parallel split (combinational)
    input wire split_in1,
    input wire split_in2,
    output wire split_out1,
    output wire split_out2,
    // parallel join element
    input wire join_in1,
    input wire join_in2,
    input wire join_in3,
    input wire join_in4,
    input wire join_trans,
    output wire join_step1_out,
    output wire join_step2_out,
    output wire join_trans_out,
    // scan pulse seen by outside logic
    output wire scan_tick
);
    localparam SCAN_CYC_RAW = (SCAN_NS + `SFCSEQ_CLK_NS - 1) / `SFCSEQ_CLK_NS;
    localparam SCAN_CYC = (SCAN_CYC_RAW < 1) ? 1 : SCAN_CYC_RAW;
    localparam CW = 16;

    // the scan counter paces all latch updates
    reg [CW-1:0] scan_cnt_reg;
    reg tick_reg;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scan_cnt_reg <= {CW{1'b0}};
            tick_reg <= 1'b0;
        end else if (scan_cnt_reg == SCAN_CYC[CW-1:0] - 16'h0001) begin
            scan_cnt_reg <= {CW{1'b0}};
            tick_reg <= 1'b1; // R21
        end else begin
            scan_cnt_reg <= scan_cnt_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end
    assign scan_tick = tick_reg;

    // start events are caught until the next scan so a short pulse is not lost
    reg start_pend_reg;
    reg pwr_pend_reg;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            start_pend_reg <= 1'b1;
            pwr_pend_reg <= 1'b0;
        end else begin
            if (init_req)
                start_pend_reg <= 1'b1;
            else if (tick_reg)
                start_pend_reg <= 1'b0;
            if (power_return)
                pwr_pend_reg <= 1'b1;
            else if (tick_reg)
                pwr_pend_reg <= 1'b0;
        end
    end

    // retention: with a resettable step, power return keeps the state, only reset,
    // program start and run entry force the pattern
    wire auto_init = start_pend_reg || (pwr_pend_reg && !HAS_RESET_INIT); // R5 R8
    // reset input has no default and acts only in this chart; R10 relies on
    // the surrounding logic tying it to cold start
    wire rst_force = HAS_RESET_INIT && chart_reset; // R7 R11 R20
    wire force_en = auto_init || rst_force; // R19
    wire hold_en = pwr_pend_reg && HAS_RESET_INIT; // R8

    sfcseq_step u_init (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .scan_tick(tick_reg),
        .force_en(force_en),
        .force_val(`SFCSEQ_INIT_RST),
        .hold_en(hold_en),
        .step_in1(init_in1),
        .step_in2(init_in2),
        .trans_in(init_trans),
        .step_out(init_step_out),
        .trans_out_reg(init_trans_out)
    );

    wire rinit_step_w;
    wire rinit_trans_w;
    sfcseq_step u_rinit (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .scan_tick(tick_reg),
        .force_en(force_en),
        .force_val(`SFCSEQ_INIT_RST),
        .hold_en(hold_en),
        .step_in1(rinit_in1),
        .step_in2(rinit_in2),
        .trans_in(rinit_trans),
        .step_out(rinit_step_w),
        .trans_out_reg(rinit_trans_w)
    );
    assign rinit_step_out = HAS_RESET_INIT ? rinit_step_w : 1'b0; // R9
    assign rinit_trans_out = HAS_RESET_INIT ? rinit_trans_w : 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < N_STEPS; gi = gi + 1) begin : g_step
            sfcseq_step u_step (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .scan_tick(tick_reg),
                .force_en(force_en),
                .force_val(`SFCSEQ_STEP_RST),
                .hold_en(hold_en),
                .step_in1(step_in1[gi]),
                .step_in2(step_in2[gi]),
                .trans_in(step_trans[gi]),
                .step_out(step_out[gi]),
                .trans_out_reg(step_trans_out[gi])
            );
        end
    endgenerate

    // split passes the token straight through, no latch
    assign split_out1 = split_in1 || split_in2; // R12 R13
    assign split_out2 = split_in1 || split_in2; // R12 R13

    // parallel join element: two branch latches released together
    reg join1_reg;
    reg join2_reg;
    reg join_tr_reg;
    reg join1_next;
    reg join2_next;
    reg join_tr_next;
    always @* begin
        join1_next = join1_reg;
        join2_next = join2_reg;
        join_tr_next = 1'b0; // R18
        if (force_en) begin
            join1_next = 1'b0;
            join2_next = 1'b0;
        end else if (!hold_en) begin
            if (join_trans && join1_reg && join2_reg) begin
                join1_next = 1'b0; // R16
                join2_next = 1'b0;
                join_tr_next = 1'b1;
            end else begin
                // R17: a lone branch is kept, no transition pulse
                if (join_in1 || join_in2)
                    join1_next = 1'b1; // R14
                if (join_in3 || join_in4)
                    join2_next = 1'b1; // R15
            end
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            join1_reg <= 1'b0;
            join2_reg <= 1'b0;
            join_tr_reg <= 1'b0;
        end else if (tick_reg) begin
            join1_reg <= join1_next; // R21
            join2_reg <= join2_next;
            join_tr_reg <= join_tr_next;
        end else begin
            join_tr_reg <= 1'b0;
        end
    end
    assign join_step1_out = join1_reg;
    assign join_step2_out = join2_reg;
    assign join_trans_out = join_tr_reg;
    // R4: unused inputs must be tied low by the integrator; no pulls exist in logic
    // R6: the chart always carries one initial step instance
endmodule

// *** sfcseq_props.sv ***
// assertion checker for the sfc chart ports
`timescale 1ns/1ps
module sfcseq_props #(parameter N_STEPS = 4) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // controls and token inputs
    input wire logic init_req,
    input wire logic power_return,
    input wire logic chart_reset,
    input wire logic [N_STEPS-1:0] step_in1,
    input wire logic [N_STEPS-1:0] step_trans,
    input wire logic split_in1,
    input wire logic split_in2,
    input wire logic join_in3,
    input wire logic join_in4,
    input wire logic join_trans,
    // outputs
    input wire logic [N_STEPS-1:0] step_out,
    input wire logic [N_STEPS-1:0] step_trans_out,
    input wire logic split_out1,
    input wire logic join_step1_out,
    input wire logic join_step2_out,
    input wire logic join_trans_out,
    input wire logic init_step_out,
    input wire logic rinit_step_out,
    input wire logic scan_tick
);
    logic pend_reg;
    logic quiet;
    // a start or power return forces or freezes the next scan, so skip it
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) pend_reg <= 1'b1;
        else if (init_req || power_return) pend_reg <= 1'b1;
        else if (scan_tick) pend_reg <= 1'b0;
    end
    assign quiet = scan_tick && !pend_reg && !init_req && !power_return && !chart_reset;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    split_follow_a: assert property (split_out1 == (split_in1 || split_in2))
        else $error("split output differs from its inputs");
    step_latch_a: assert property (quiet && step_in1[0] && !step_trans[0] |=> step_out[0])
        else $error("step did not latch");
    step_pass_a: assert property (quiet && step_out[0] && step_trans[0]
        |=> !step_out[0] && step_trans_out[0] ##1 !step_trans_out[0])
        else $error("step token not handed on");
    scan_only_a: assert property (!scan_tick |=> $stable(step_out) && $stable(join_step1_out))
        else $error("step changed between scans");
    join_fire_a: assert property (quiet && join_step1_out && join_step2_out && join_trans
        |=> !join_step1_out && !join_step2_out && join_trans_out)
        else $error("join did not fire");
    join_wait_a: assert property (quiet && join_trans && !join_step2_out
        && !join_in3 && !join_in4 |=> !join_trans_out && !join_step2_out)
        else $error("join fired with a branch missing");
    reset_force_a: assert property (scan_tick && chart_reset
        |=> rinit_step_out && init_step_out && step_out == '0 && !join_step2_out)
        else $error("chart reset did not force initial pattern");
    join_pulse_a: assert property (join_trans_out |=> !join_trans_out)
        else $error("join transition output stuck");
endmodule
bind sfcseq_chart sfcseq_props #(.N_STEPS(N_STEPS)) sfcseq_props_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .init_req(init_req), .power_return(power_return),
    .chart_reset(chart_reset), .step_in1(step_in1), .step_trans(step_trans),
    .split_in1(split_in1), .split_in2(split_in2), .join_in3(join_in3), .join_in4(join_in4),
    .join_trans(join_trans), .step_out(step_out), .step_trans_out(step_trans_out),
    .split_out1(split_out1), .join_step1_out(join_step1_out), .join_step2_out(join_step2_out),
    .join_trans_out(join_trans_out), .init_step_out(init_step_out),
    .rinit_step_out(rinit_step_out), .scan_tick(scan_tick));

// *** sfcseq_env.sv ***
// outside logic model: cold-start indication drives the chart reset
`timescale 1ns/1ps
module sfcseq_env (
    // cold-start indication
    input wire logic cold_start,
    // reset of the resettable initial step
    output wire logic chart_reset
);
    // no filtering, so the chart is forced for the whole cold start
    assign chart_reset = cold_start;
endmodule

// *** sfcseq_chart_tb.sv ***
// self-checking bench for the sfc chart
`timescale 1ns/1ps
module sfcseq_chart_tb;
    logic clk_sys = 1'b0, arst_n = 1'b0, init_req = 1'b0, power_return = 1'b0;
    logic cold_start = 1'b1, init_in1 = 1'b0, init_in2 = 1'b0, init_trans = 1'b0;
    logic rinit_in1 = 1'b0, rinit_in2 = 1'b0, rinit_trans = 1'b0, join_trans = 1'b0;
    logic split_in1 = 1'b0, split_in2 = 1'b0;
    logic [3:0] step_in1 = 4'h0, step_in2 = 4'h0, step_trans = 4'h0, join_in = 4'h0;
    wire chart_reset, init_step_out, init_trans_out, rinit_step_out, rinit_trans_out;
    wire split_out1, split_out2, join_step1_out, join_step2_out, join_trans_out, scan_tick;
    wire [3:0] step_out, step_trans_out;
    int n_errors = 0, n_compared = 0;
    int gap = 0;
    // inputs: in1 in2 trans, join in1..in4 trans; outputs: step pulse, join1 join2 pulse
    logic [7:0] in_rows [10] = '{8'h00, 8'h21, 8'h90, 8'h01, 8'h22, 8'h40, 8'h61, 8'h0c,
        8'h01, 8'h00};
    logic [4:0] exp_rows [10] = '{5'h00, 5'h00, 5'h14, 5'h14, 5'h0e, 5'h16, 5'h09, 5'h06,
        5'h01, 5'h00};
    sfcseq_env sfcseq_env_i (.cold_start(cold_start), .chart_reset(chart_reset));
    sfcseq_chart #(.SCAN_NS(20)) sfcseq_chart_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .init_req(init_req), .power_return(power_return), .chart_reset(chart_reset),
        .init_in1(init_in1), .init_in2(init_in2), .init_trans(init_trans),
        .init_step_out(init_step_out), .init_trans_out(init_trans_out),
        .rinit_in1(rinit_in1), .rinit_in2(rinit_in2), .rinit_trans(rinit_trans),
        .rinit_step_out(rinit_step_out), .rinit_trans_out(rinit_trans_out),
        .step_in1(step_in1), .step_in2(step_in2), .step_trans(step_trans),
        .step_out(step_out), .step_trans_out(step_trans_out), .split_in1(split_in1),
        .split_in2(split_in2), .split_out1(split_out1), .split_out2(split_out2),
        .join_in1(join_in[3]), .join_in2(join_in[2]), .join_in3(join_in[1]),
        .join_in4(join_in[0]), .join_trans(join_trans), .join_step1_out(join_step1_out),
        .join_step2_out(join_step2_out), .join_trans_out(join_trans_out),
        .scan_tick(scan_tick));
    always #2.5 clk_sys = ~clk_sys;
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // returns just after the edge that took the next scan
    task automatic scan;
        int k;
        k = 0;
        while (scan_tick !== 1'b1 && k < 50) begin
            @(posedge clk_sys);
            #1 k++;
        end
        // a scan that never comes is a failure, not a silent pass
        if (scan_tick !== 1'b1)
            n_errors++;
        @(posedge clk_sys);
        #1;
    endtask
    initial begin
        #5000 n_errors++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        scan;
        check("start initial", {2'h0, init_step_out, rinit_step_out}, 4'h3);
        check("start steps", step_out, 4'h0);
        cold_start = 1'b0;
        for (int i = 0; i < 10; i++) begin
            {step_in1, step_in2, step_trans} = {{4{in_rows[i][7]}}, {4{in_rows[i][6]}},
                {4{in_rows[i][5]}}};
            {join_in, join_trans} = in_rows[i][4:0];
            {split_in1, split_in2} = in_rows[i][7:6];
            #1 check("split", {split_out1, split_out2}, {2{in_rows[i][7] | in_rows[i][6]}});
            scan;
            check("step", step_out, {4{exp_rows[i][4]}});
            check("step pulse", step_trans_out, {4{exp_rows[i][3]}});
            check("join", {join_step1_out, join_step2_out, join_trans_out},
                exp_rows[i][2:0]);
        end
        {init_trans, rinit_trans, step_in1} = {2'h3, 4'hf};
        scan;
        check("initial pass", {init_step_out, rinit_step_out, init_trans_out, rinit_trans_out},
            4'h3);
        {init_trans, rinit_trans, init_in1, rinit_in2, step_in1} = {4'h3, 4'h0};
        scan;
        check("initial set", {2'h0, init_step_out, rinit_step_out}, 4'h3);
        {init_in1, rinit_in2, power_return, step_trans} = {3'h1, 4'hf};
        @(posedge clk_sys);
        #1 power_return = 1'b0;
        scan;
        check("retained steps", step_out, 4'hf);
        {step_trans, step_in1, cold_start, join_in} = {4'h0, 4'h5, 1'b1, 4'hf};
        repeat (2) scan;
        check("steps in reset", step_out, 4'h0);
        check("initial in reset", {1'h0, join_step1_out, init_step_out, rinit_step_out},
            4'h3);
        cold_start = 1'b0;
        scan;
        check("steps after reset", step_out, 4'h5);
        // 20 ns scan on a 5 ns clock: three idle edges between ticks
        while (scan_tick !== 1'b1 && gap < 50) begin
            @(posedge clk_sys);
            #1 gap++;
        end
        check("scan gap", gap[3:0], 4'h3);
        // run entry request while steps and join branches are active
        init_req = 1'b1;
        @(posedge clk_sys);
        #1 init_req = 1'b0;
        scan;
        check("run entry steps", step_out, 4'h0);
        check("run entry initial", {init_step_out, rinit_step_out, join_step1_out, join_step2_out},
            4'hc);
        give_verdict;
    end
endmodule
